/* hdl/byte_ram.sv */
// Byte RAM with clocked write and combinational read
`timescale 1ns/1ps
`default_nettype none
module byte_ram #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          clk_i,   // System clock
  input  wire logic          we_i,    // Write enable
  input  wire logic [AW-1:0] addr_i,  // Byte index
  input  wire logic [7:0]    wdata_i, // Write data
  output logic      [7:0]    rdata_o  // Read data
);
  logic [7:0] mem [DEPTH];

  // Read is combinational so one-clock accesses can finish in place
  assign rdata_o = mem[addr_i];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end
endmodule
`default_nettype wire

/* hdl/mbcu.sv */
// Memory and external bus control unit with prefetch queue
`timescale 1ns/1ps
`default_nettype none
`include "mbcu_defines.svh"
module mbcu (
  input  wire logic            CLK_I,        // System clock
  input  wire logic            RESET_I,      // Sync reset, high
  input  wire logic            REQ_I,        // Data access request
  input  wire mbcu_pkg::amode_t REQ_MODE_I,  // Addressing mode
  input  wire logic [15:0]     REQ_ADDR_I,   // Address/offset/reg
  input  wire logic            REQ_WRITE_I,  // Write when high
  input  wire logic            REQ_WORD_I,   // Word form access
  input  wire logic [7:0]      REQ_WDATA_I,  // Write data
  output logic                 ACK_O,        // Access done pulse
  output logic [7:0]           RDATA_O,      // Read data
  output logic                 ALIGN_ERR_O,  // Odd word refused
  input  wire logic            Q_POP_I,      // Take queue head
  input  wire logic            Q_FLUSH_I,    // Flush and redirect
  input  wire logic [15:0]     Q_PC_I,       // New fetch address
  output logic                 Q_VALID_O,    // Queue not empty
  output logic [7:0]           Q_DATA_O,     // Queue head byte
  output logic [2:0]           Q_COUNT_O,    // Bytes queued
  output logic                 FETCH_FAULT_O, // Fetch address barred
  output logic                 BOOT_DONE_O,  // Reset vector loaded
  output logic [15:0]          BOOT_PC_O,    // Loaded start address
  input  wire logic            PSW_WE_I,     // Status word write
  input  wire logic [15:0]     PSW_D_I,      // Status word data
  output logic [15:0]          PSW_O,        // Status word
  output logic [7:0]           CCW_O,        // CPU control word
  input  wire mbcu_pkg::vsel_t VEC_SEL_I,    // Vector kind
  input  wire logic [4:0]      VEC_IDX_I,    // Table index
  output logic [15:0]          VEC_ADDR_O,   // Vector address
  output logic [15:0]          PROG_ADDR_O,  // Program memory addr
  input  wire logic [7:0]      PROG_DATA_I,  // Program memory data
  output logic [7:0]           AD_O,         // Addr/data out
  input  wire logic [7:0]      AD_I,         // Addr/data pin level
  output logic                 AD_OE_N_O,    // Addr/data enable, low
  output logic [7:0]           A_HI_O,       // High address
  output logic [7:0]           A_HI_OE_N_O,  // High line enable, low
  output logic                 ADDRESS_LATCH_STROBE_O,       // Address latch strobe
  output logic                 RD_N_O,       // Read strobe, low
  output logic                 WR_N_O,       // Write strobe, low
  input  wire logic            WAIT_N_I      // Wait request, low
);
  import mbcu_pkg::*;

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function automatic logic [16:0] ext_size(input logic [7:0] mm);
    case (mm[2:0])
      3'h0:    ext_size = 17'h00000;
      3'h1:    ext_size = 17'h00100;
      3'h2:    ext_size = 17'h01000;
      3'h3:    ext_size = 17'h04000;
      default: ext_size = 17'h08000;
    endcase
  endfunction

  function automatic logic [7:0] hi_mask(input logic [7:0] mm);
    case (mm[2:0])
      3'h0, 3'h1: hi_mask = 8'h00;
      3'h2:       hi_mask = 8'h0F;
      3'h3:       hi_mask = 8'h3F;
      default:    hi_mask = 8'hFF;
    endcase
  endfunction

  function automatic region_t region_of(input logic [15:0] a,
                                        input logic [7:0] mm);
    logic [16:0] off;
    off = {1'b0, a} - {1'b0, `EXT_BASE};
    if (a >= `MAIN_RAM_BASE && a <= `MAIN_RAM_LAST) region_of = RG_MAIN;
    else if (a >= `PERI_RAM_BASE && a <= `PERI_RAM_LAST) region_of = RG_PERI;
    else if (a >= `EXTACC_FIRST && a <= `EXTACC_LAST) region_of = RG_EXT;
    else if (a >= `SFR_BASE) region_of = RG_SFR;
    else if (a < `EXT_BASE) region_of = RG_PROG;
    else if (off < ext_size(mm)) region_of = RG_EXT;
    else region_of = RG_NONE;
  endfunction

  function automatic logic [1:0] wait2(input logic [1:0] code);
    wait2 = (code == 2'h3) ? 2'h2 : code;
  endfunction

  function automatic logic [3:0] cycles(input region_t rg, input amode_t m,
                                        input logic fetch,
                                        input logic [15:0] wait_state_control,
                                        input logic [15:0] a);
    case (rg)
      RG_MAIN: cycles = (m == MODE_MEM) ? `MEM_CYC : `SHORT_CYC;
      RG_PERI: cycles = `SLOW_CYC;
      RG_PROG: cycles = fetch ? `MEM_CYC + {2'h0, wait_state_control[`FRATE_LSB +: 2]}
                      : `MEM_CYC + {2'h0, wait2(wait_state_control[`IWAIT_LSB + 2*a[14] +: 2])};
      RG_SFR:  cycles = `MEM_CYC;
      default: cycles = `SHORT_CYC;
    endcase
  endfunction

  function automatic logic [15:0] eff_addr(input amode_t m,
                                           input logic [15:0] a,
                                           input logic [15:0] program_status_word);
    logic [3:0] r;
    r = a[3:0];
    if (m == MODE_SADDR) begin
      eff_addr = (a[7:0] < `SADDR_SFR_SPAN) ? {8'hFF, a[7:0]}
                                            : {8'hFE, a[7:0]};
    end else if (m == MODE_REG) begin
      if (program_status_word[`RSS_BIT] && !r[3]) begin
        r[2] = ~r[2];
      end
      eff_addr = `GPR_BASE + {9'h000, program_status_word[`BANK_MSB:`BANK_LSB], r};
    end else begin
      eff_addr = a;
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_t      state_q, state_d;
  owner_t      owner_q, fin_owner;
  region_t     region_q, acc_region, start_region, fregion;
  logic [15:0] addr_q, acc_addr, start_addr, fpc_q, pwc_q, psw_q;
  logic [7:0]  wdata_q, acc_wdata, mm_q, rd_val, boot_lo_q;
  logic [7:0]  main_rd, peri_rd, ad_m_q, ad_s_q, qmem [5];
  logic [3:0]  cnt_q, start_cyc;
  logic [2:0]  qcount_q, qcount_d, qlimit, qwr_q, qrd_q;
  logic [1:0]  boot_q;
  logic        write_q, acc_write, stretch_q, drop_q, wait_m_q, wait_s_q;
  logic        idle, boot_busy, take_data, take_fetch, fetch_ok, misalign;
  logic        fin, push, pop;

  // Pins come from outside the clock domain
  always_ff @(posedge CLK_I) begin
    wait_m_q <= WAIT_N_I;
    wait_s_q <= wait_m_q;
    ad_m_q   <= AD_I;
    ad_s_q   <= ad_m_q;
  end

  // ----------------------------------------------------------------
  // Request selection
  // ----------------------------------------------------------------
  always_comb begin
    idle       = (state_q == ST_IDLE);
    boot_busy  = (boot_q != 2'h2);
    fregion    = region_of(fpc_q, mm_q);
    qlimit     = (fregion == RG_EXT) ? `Q_EXT_DEPTH : `Q_INT_DEPTH;
    fetch_ok   = (fpc_q <= `FETCH_LAST) && (fregion != RG_NONE);
    // No retake in the answer cycle: the master drops REQ_I at the next edge
    take_data  = idle && REQ_I && !boot_busy && !ACK_O && !ALIGN_ERR_O;
    // Execution unit wins the bus over fetches once the boot reads are done
    take_fetch = idle && !REQ_I && !boot_busy && fetch_ok && !Q_FLUSH_I
                 && (qcount_q < qlimit);
    misalign   = take_data && REQ_WORD_I && (REQ_MODE_I == MODE_SADDR)
                 && REQ_ADDR_I[0];
    if (boot_busy) start_addr = `RESET_VEC + {15'h0000, boot_q[0]};
    else if (take_data) start_addr = eff_addr(REQ_MODE_I, REQ_ADDR_I, psw_q);
    else start_addr = fpc_q;
    start_region = region_of(start_addr, mm_q);
    start_cyc  = cycles(start_region, take_data ? REQ_MODE_I : MODE_MEM,
                        !take_data, pwc_q, start_addr);
    acc_addr   = idle ? start_addr : addr_q;
    acc_region = idle ? (misalign ? RG_NONE : start_region) : region_q;
    acc_write  = idle ? (take_data && REQ_WRITE_I && !misalign) : write_q;
    acc_wdata  = idle ? REQ_WDATA_I : wdata_q;
    fin_owner  = idle ? OWN_DATA : owner_q;
    fin = (take_data && (misalign || (start_region != RG_EXT
                                      && start_cyc == `SHORT_CYC)))
          || (state_q == ST_INT && cnt_q == 4'h0)
          || (state_q == ST_EXT_DATA && cnt_q == 4'h0 && wait_s_q);
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if ((take_data && !misalign) || take_fetch || boot_busy) begin
          if (start_region == RG_EXT) state_d = ST_EXT_ADDR;
          else if (start_cyc != `SHORT_CYC) state_d = ST_INT;
        end
      end
      ST_INT:         state_d = fin ? ST_IDLE : ST_INT;
      ST_EXT_ADDR:    state_d = stretch_q ? ST_EXT_STRETCH : ST_EXT_DATA;
      ST_EXT_STRETCH: state_d = ST_EXT_DATA;
      ST_EXT_DATA:    state_d = fin ? ST_IDLE : ST_EXT_DATA;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      state_q   <= ST_IDLE;
      owner_q   <= OWN_DATA;
      region_q  <= RG_NONE;
      addr_q    <= 16'h0000;
      write_q   <= 1'b0;
      wdata_q   <= 8'h00;
      cnt_q     <= 4'h0;
      stretch_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (idle && state_d != ST_IDLE) begin
        owner_q   <= boot_busy ? OWN_BOOT : (take_data ? OWN_DATA : OWN_FETCH);
        region_q  <= start_region;
        addr_q    <= start_addr;
        write_q   <= acc_write;
        wdata_q   <= REQ_WDATA_I;
        // External base is three clocks: address, two strobe clocks
        cnt_q     <= (start_region == RG_EXT)
                     ? 4'h1 + {2'h0, wait2(pwc_q[2*start_addr[15:14] +: 2])}
                     : start_cyc - 4'h2;
        stretch_q <= start_addr[15]
                     ? (pwc_q[`AW1_BIT] && start_addr <= `AW1_LAST)
                     : pwc_q[`AW0_BIT];
      end else if (cnt_q != 4'h0 && (state_q == ST_INT
                                     || state_q == ST_EXT_DATA)) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Storage and read mux
  // ----------------------------------------------------------------
  byte_ram #(.DEPTH(256), .AW(8)) u_main (
    .clk_i   (CLK_I),
    .we_i    (fin && acc_write && acc_region == RG_MAIN),
    .addr_i  (acc_addr[7:0]),
    .wdata_i (acc_wdata),
    .rdata_o (main_rd)
  );

  byte_ram #(.DEPTH(384), .AW(9)) u_peri (
    .clk_i   (CLK_I),
    .we_i    (fin && acc_write && acc_region == RG_PERI),
    .addr_i  (9'(acc_addr - `PERI_RAM_BASE)),
    .wdata_i (acc_wdata),
    .rdata_o (peri_rd)
  );

  always_comb begin
    unique case (acc_region)
      RG_MAIN: rd_val = main_rd;
      RG_PERI: rd_val = peri_rd;
      RG_PROG: rd_val = PROG_DATA_I;
      RG_EXT:  rd_val = ad_s_q;
      RG_SFR: begin
        if (acc_addr == `CCW_ADDR) rd_val = CCW_O;
        else if (acc_addr == `MM_ADDR) rd_val = mm_q;
        else if (acc_addr == `PWC_LO_ADDR) rd_val = pwc_q[7:0];
        else if (acc_addr == `PWC_HI_ADDR) rd_val = pwc_q[15:8];
        else rd_val = 8'h00;
      end
      default: rd_val = 8'h00;
    endcase
  end

  // Control registers
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      CCW_O <= `CCW_RST;
      mm_q  <= `MM_RST;
      pwc_q <= `PWC_RST;
      psw_q <= `PSW_RST;
    end else begin
      if (fin && acc_write && acc_region == RG_SFR) begin
        if (acc_addr == `CCW_ADDR) CCW_O <= acc_wdata;
        if (acc_addr == `MM_ADDR) mm_q <= acc_wdata;
        if (acc_addr == `PWC_LO_ADDR) pwc_q[7:0] <= acc_wdata;
        if (acc_addr == `PWC_HI_ADDR) pwc_q[15:8] <= acc_wdata;
      end
      if (PSW_WE_I) psw_q <= PSW_D_I;
    end
  end
  assign PSW_O = psw_q;

  // ----------------------------------------------------------------
  // Answers, vectors and boot
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      ACK_O       <= 1'b0;
      RDATA_O     <= 8'h00;
      ALIGN_ERR_O <= 1'b0;
      VEC_ADDR_O  <= `RESET_VEC;
      PROG_ADDR_O <= 16'h0000;
    end else begin
      ACK_O       <= fin && fin_owner == OWN_DATA;
      ALIGN_ERR_O <= misalign;
      PROG_ADDR_O <= acc_addr;
      if (fin && fin_owner == OWN_DATA) RDATA_O <= rd_val;
      unique case (VEC_SEL_I)
        VEC_RESET: VEC_ADDR_O <= `RESET_VEC;
        VEC_TRAP:  VEC_ADDR_O <= `TRAP_VEC;
        VEC_BRK:   VEC_ADDR_O <= `BRK_VEC;
        VEC_TABLE: VEC_ADDR_O <= (CCW_O[`TPF_BIT] ? `TABLE_ALT_BASE : 16'h0000)
                                 + {10'h000, VEC_IDX_I, 1'b0};
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      boot_q      <= 2'h0;
      boot_lo_q   <= 8'h00;
      BOOT_DONE_O <= 1'b0;
      BOOT_PC_O   <= 16'h0000;
    end else if (fin && fin_owner == OWN_BOOT) begin
      boot_q <= boot_q + 2'h1;
      if (boot_q == 2'h0) boot_lo_q <= rd_val;
      else begin
        BOOT_DONE_O <= 1'b1;
        BOOT_PC_O   <= {rd_val, boot_lo_q};
      end
    end
  end

  // ----------------------------------------------------------------
  // Prefetch queue
  // ----------------------------------------------------------------
  always_comb begin
    push     = fin && fin_owner == OWN_FETCH && !drop_q && !Q_FLUSH_I;
    pop      = Q_POP_I && qcount_q != 3'h0;
    qcount_d = Q_FLUSH_I ? 3'h0
               : qcount_q + {2'h0, push} - {2'h0, pop};
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      qcount_q      <= 3'h0;
      qwr_q         <= 3'h0;
      qrd_q         <= 3'h0;
      fpc_q         <= 16'h0000;
      drop_q        <= 1'b0;
      Q_VALID_O     <= 1'b0;
      FETCH_FAULT_O <= 1'b0;
    end else begin
      qcount_q      <= qcount_d;
      Q_VALID_O     <= qcount_d != 3'h0;
      FETCH_FAULT_O <= !boot_busy && !fetch_ok;
      // A fetch already on the bus when flushed is thrown away
      if (Q_FLUSH_I && !idle && owner_q == OWN_FETCH && !fin) drop_q <= 1'b1;
      else if (fin) drop_q <= 1'b0;
      if (Q_FLUSH_I) begin
        qwr_q <= 3'h0;
        qrd_q <= 3'h0;
        fpc_q <= Q_PC_I;
      end else begin
        if (push) begin
          qmem[qwr_q] <= rd_val;
          qwr_q <= (qwr_q == 3'h4) ? 3'h0 : qwr_q + 3'h1;
          fpc_q <= fpc_q + 16'h0001;
        end
        if (pop) qrd_q <= (qrd_q == 3'h4) ? 3'h0 : qrd_q + 3'h1;
        if (fin && fin_owner == OWN_BOOT && boot_q == 2'h1) begin
          fpc_q <= {rd_val, boot_lo_q};
        end
      end
    end
  end
  assign Q_COUNT_O = qcount_q;
  assign Q_DATA_O  = qmem[qrd_q];

  // ----------------------------------------------------------------
  // External bus pins
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      ADDRESS_LATCH_STROBE_O      <= 1'b0;
      RD_N_O      <= 1'b1;
      WR_N_O      <= 1'b1;
      AD_O        <= 8'h00;
      AD_OE_N_O   <= 1'b1;
      A_HI_O      <= 8'h00;
      A_HI_OE_N_O <= 8'hFF;
    end else begin
      A_HI_OE_N_O <= ~hi_mask(mm_q);
      ADDRESS_LATCH_STROBE_O <= state_d == ST_EXT_ADDR || state_d == ST_EXT_STRETCH;
      RD_N_O <= !(state_d == ST_EXT_DATA && !acc_write);
      WR_N_O <= !(state_d == ST_EXT_DATA && acc_write);
      if (state_d == ST_EXT_ADDR || state_d == ST_EXT_STRETCH) begin
        AD_O      <= acc_addr[7:0];
        AD_OE_N_O <= 1'b0;
        A_HI_O    <= acc_addr[15:8];
      end else if (state_d == ST_EXT_DATA) begin
        AD_O      <= acc_wdata;
        AD_OE_N_O <= !acc_write;
      end else begin
        AD_OE_N_O <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  property p_short_one;
    take_data && !misalign && REQ_MODE_I != MODE_MEM
      && start_region == RG_MAIN |-> ##1 ACK_O;
  endproperty
  a_short_one: assert property (p_short_one) else $error("short access late");

  property p_main_two;
    take_data && REQ_MODE_I == MODE_MEM && start_region == RG_MAIN
      |-> ##1 !ACK_O ##1 ACK_O;
  endproperty
  a_main_two: assert property (p_main_two) else $error("main RAM not 2 clocks");

  property p_peri_three;
    take_data && !misalign && start_region == RG_PERI
      |-> ##1 !ACK_O ##1 !ACK_O ##1 ACK_O;
  endproperty
  a_peri_three: assert property (p_peri_three) else $error("peri RAM not 3 clocks");

  property p_fetch_range;
    take_fetch |-> fpc_q <= `FETCH_LAST;
  endproperty
  a_fetch_range: assert property (p_fetch_range) else $error("barred fetch");

  property p_yield;
    idle && REQ_I && !boot_busy |-> !take_fetch;
  endproperty
  a_yield: assert property (p_yield) else $error("fetch beat data");

  property p_qcap;
    Q_COUNT_O <= `Q_INT_DEPTH
      && !(take_fetch && fregion == RG_EXT && Q_COUNT_O >= `Q_EXT_DEPTH);
  endproperty
  a_qcap: assert property (p_qcap) else $error("queue over limit");

  property p_ext_strobe;
    $rose(ADDRESS_LATCH_STROBE_O) |-> !AD_OE_N_O && RD_N_O && WR_N_O;
  endproperty
  a_ext_strobe: assert property (p_ext_strobe) else $error("address phase bad");

  property p_read_release;
    !RD_N_O |-> AD_OE_N_O && !ADDRESS_LATCH_STROBE_O;
  endproperty
  a_read_release: assert property (p_read_release) else $error("bus not released");

  property p_wait_hold;
    state_q == ST_EXT_DATA && cnt_q == 4'h0 && !wait_s_q
      |=> state_q == ST_EXT_DATA && (!RD_N_O || !WR_N_O);
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("wait ignored");

  property p_trap_fixed;
    VEC_SEL_I == VEC_TRAP |=> VEC_ADDR_O == `TRAP_VEC;
  endproperty
  a_trap_fixed: assert property (p_trap_fixed) else $error("trap vector moved");

  property p_boot_pc;
    $rose(BOOT_DONE_O) |-> fpc_q == BOOT_PC_O;
  endproperty
  a_boot_pc: assert property (p_boot_pc) else $error("boot PC mismatch");

  c_ext_read:   cover property ($fell(RD_N_O) ##[1:20] ACK_O);
  c_ext_fetch:  cover property (take_fetch && fregion == RG_EXT);
  c_wait_ext:   cover property (state_q == ST_EXT_DATA && !wait_s_q);
  c_flush_drop: cover property (drop_q && fin);
endmodule
`default_nettype wire

/* hdl/mbcu_defines.svh */
// Constants for the memory and bus control unit
`ifndef MBCU_DEFINES_SVH
`define MBCU_DEFINES_SVH
`define MAIN_RAM_BASE  16'hFE00
`define MAIN_RAM_LAST  16'hFEFF
`define PERI_RAM_BASE  16'hFC80
`define PERI_RAM_LAST  16'hFDFF
`define FETCH_LAST     16'hFDFF
`define EXT_BASE       16'h8000
`define SFR_BASE       16'hFF00
`define EXTACC_FIRST   16'hFFD0
`define EXTACC_LAST    16'hFFDF
`define AW1_LAST       16'hFC7F
`define CCW_ADDR       16'hFFC1
`define MM_ADDR        16'hFFC4
`define PWC_LO_ADDR    16'hFFC6
`define PWC_HI_ADDR    16'hFFC7
`define CCW_RST        8'h00
`define MM_RST         8'h00
`define PWC_RST        16'hC0AA
`define PSW_RST        16'h0000
`define TPF_BIT        1
`define AW0_BIT        8
`define AW1_BIT        9
`define IWAIT_LSB      10
`define FRATE_LSB      14
`define RSS_BIT        5
`define BANK_LSB       12
`define BANK_MSB       14
`define SADDR_SFR_SPAN 8'h20
`define GPR_BASE       16'hFE80
`define TABLE_ALT_BASE 16'h8000
`define RESET_VEC      16'h0000
`define TRAP_VEC       16'h003C
`define BRK_VEC        16'h003E
`define SHORT_CALL_TABLE_OFS      16'h0040
`define MEM_CYC        4'h2
`define SHORT_CYC      4'h1
`define SLOW_CYC       4'h3
`define Q_INT_DEPTH    3'h5
`define Q_EXT_DEPTH    3'h3
`endif

/* hdl/mbcu_pkg.sv */
// Types shared by the memory and bus control unit
package mbcu_pkg;
  typedef enum logic [1:0] {MODE_MEM, MODE_SADDR, MODE_REG} amode_t;
  typedef enum logic [1:0] {VEC_RESET, VEC_TRAP, VEC_BRK, VEC_TABLE} vsel_t;
  typedef enum logic [2:0] {RG_MAIN, RG_PERI, RG_PROG, RG_EXT, RG_SFR,
                            RG_NONE} region_t;
  typedef enum logic [1:0] {OWN_DATA, OWN_FETCH, OWN_BOOT} owner_t;
  typedef enum logic [2:0] {ST_IDLE, ST_INT, ST_EXT_ADDR, ST_EXT_STRETCH,
                            ST_EXT_DATA} state_t;
endpackage

/* testbench/ext_mem_model.sv */
// External memory model on the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  input  wire logic       clk_i,   // Clock
  input  wire logic       address_latch_strobe_i,  // Address strobe
  input  wire logic       rd_n_i,  // Read, low
  input  wire logic       wr_n_i,  // Write, low
  input  wire logic [7:0] ad_i,    // Bus level
  input  wire logic [3:0] stall_i, // Waits to add
  output logic      [7:0] ad_o,    // Driven byte
  output logic            wait_n_o // Wait, low
);
  logic [7:0] mem [256];
  logic [7:0] adr = 8'h00;
  logic [3:0] cnt = 4'h0;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
  // Released bus shows inverted data, never a stale copy
  assign ad_o = rd_n_i ? ~mem[adr] : mem[adr];
  assign wait_n_o = (cnt == 4'h0);
  always @(posedge clk_i) begin
    if (address_latch_strobe_i) adr <= ad_i;
    if (!wr_n_i) mem[adr] <= ad_i;
    cnt <= address_latch_strobe_i ? stall_i : cnt - 4'(cnt != 4'h0);
  end
endmodule
`default_nettype wire

/* testbench/memory_bus_control_unit_tb_top.sv */
// Bench for the memory and bus control unit
`timescale 1ns/1ps
`default_nettype none
module memory_bus_control_unit_tb_top;
  import mbcu_pkg::*;
  logic clk = 0, rst = 1, req = 0, wr = 0, wd = 0, pop = 0, fl = 0, pwe = 0;
  amode_t md = MODE_MEM;
  vsel_t vs = VEC_RESET;
  logic [15:0] a = 0, pc = 0, pd = 0, bpc, program_status_word, va, pa;
  logic [15:0] ve [4] = '{16'h0000, 16'h003C, 16'h003E, 16'h800A};
  logic [7:0] d = 0, rdat, ado, adev, qd, cpu_control_word, ahi, ahoe;
  logic [7:0] mdl [int];
  logic [4:0] vi = 0;
  logic [3:0] st = 0;
  logic [2:0] qc;
  logic ack, ae, qv, flt, bd, oen, address_latch_strobe, rdn, wrn, wn;
  int fail_count = 0, checked = 0, cyc = 0, n, m;
  wire [7:0] ad = oen ? adev : ado;
  mbcu i_mbcu (.CLK_I(clk), .RESET_I(rst), .REQ_I(req), .REQ_MODE_I(md),
    .REQ_ADDR_I(a), .REQ_WRITE_I(wr), .REQ_WORD_I(wd), .REQ_WDATA_I(d),
    .ACK_O(ack), .RDATA_O(rdat), .ALIGN_ERR_O(ae), .Q_POP_I(pop),
    .Q_FLUSH_I(fl), .Q_PC_I(pc), .Q_VALID_O(qv), .Q_DATA_O(qd),
    .Q_COUNT_O(qc), .FETCH_FAULT_O(flt), .BOOT_DONE_O(bd),
    .BOOT_PC_O(bpc), .PSW_WE_I(pwe), .PSW_D_I(pd), .PSW_O(program_status_word),
    .CCW_O(cpu_control_word), .VEC_SEL_I(vs), .VEC_IDX_I(vi), .VEC_ADDR_O(va),
    .PROG_ADDR_O(pa), .PROG_DATA_I(pa[7:0] ^ 8'hC3), .AD_O(ado),
    .AD_I(ad), .AD_OE_N_O(oen), .A_HI_O(ahi), .A_HI_OE_N_O(ahoe),
    .ADDRESS_LATCH_STROBE_O(address_latch_strobe), .RD_N_O(rdn), .WR_N_O(wrn), .WAIT_N_I(wn));
  ext_mem_model i_ext_mem_model (.clk_i(clk), .address_latch_strobe_i(address_latch_strobe), .rd_n_i(rdn),
    .wr_n_i(wrn), .ad_i(ad), .stall_i(st), .ad_o(adev), .wait_n_o(wn));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic finish_test();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Releases the request at the edge that samples the answer
  task automatic acc(input amode_t mm, input logic [15:0] aa,
                     input logic w, input logic [7:0] v, output int lat);
    @(posedge clk);
    md <= mm;
    a <= aa;
    wr <= w;
    d <= v;
    req <= 1;
    if (w) mdl[aa] = v;
    lat = 0;
    do begin
      @(posedge clk);
      lat++;
    end while (!ack && !ae && lat < 60);
    req <= 0;
  endtask
  task automatic flush(input logic [15:0] p);
    @(posedge clk);
    pc <= p;
    fl <= 1;
    @(posedge clk);
    fl <= 0;
    repeat (40) @(posedge clk);
  endtask
  initial begin
    void'($urandom(89));
    repeat (8) @(posedge clk);
    rst <= 0;
    n = 0;
    while (bd !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(bpc, 16'hC2C3);
    // Park fetching on a barred address so it cannot skew latencies
    flush(16'hFE00);
    chk(16'(flt), 16'h0001);
    acc(MODE_MEM, 16'hFE40, 1, 8'($urandom), n);
    acc(MODE_MEM, 16'hFE40, 0, 8'h00, n);
    chk(rdat, mdl[16'hFE40]);
    acc(MODE_SADDR, 16'h0040, 0, 8'h00, m);
    chk(rdat, mdl[16'hFE40]);
    chk(16'(n - m), 16'h0001);
    acc(MODE_MEM, 16'hFD00, 1, 8'($urandom), m);
    acc(MODE_MEM, 16'hFD00, 0, 8'h00, m);
    chk(rdat, mdl[16'hFD00]);
    chk(16'(m - n), 16'h0001);
    wd <= 1;
    acc(MODE_SADDR, 16'h0041, 0, 8'h00, m);
    chk(16'(ae), 16'h0001);
    wd <= 0;
    pd <= 16'h3000;
    pwe <= 1;
    acc(MODE_REG, 16'h0004, 1, 8'($urandom), m);
    acc(MODE_MEM, 16'hFEB4, 0, 8'h00, m);
    chk(rdat, mdl[16'h0004]);
    pd <= 16'h3020;
    acc(MODE_REG, 16'h0000, 0, 8'h00, m);
    chk(rdat, mdl[16'h0004]);
    chk(program_status_word, 16'h3020);
    pwe <= 0;
    acc(MODE_MEM, 16'hFFC1, 1, 8'h02, m);
    for (int i = 0; i < 4; i++) begin
      vs <= vsel_t'(i);
      vi <= 5'h05;
      repeat (2) @(posedge clk);
      chk(va, ve[i]);
    end
    acc(MODE_MEM, 16'hFFC4, 1, 8'h04, m);
    @(posedge clk);
    chk(16'(ahoe), 16'h0000);
    acc(MODE_MEM, 16'h8012, 1, 8'($urandom), m);
    acc(MODE_MEM, 16'h8012, 0, 8'h00, m);
    chk(rdat, mdl[16'h8012]);
    acc(MODE_MEM, 16'h8013, 0, 8'h00, n);
    chk(rdat, 8'h49);
    st <= 6;
    acc(MODE_MEM, 16'h8013, 0, 8'h00, m);
    st <= 0;
    chk(16'(m - n >= 4), 16'h0001);
    flush(16'h0010);
    chk(16'(qc), 16'h0005);
    chk(16'(qd), 16'h00D3);
    chk(16'(qv), 16'h0001);
    pop <= 1;
    @(posedge clk);
    pop <= 0;
    @(posedge clk);
    chk(16'(qd), 16'h00D2);
    flush(16'h8000);
    chk(16'(qc), 16'h0003);
    flush(16'hFFD0);
    chk(16'(flt), 16'h0001);
    flush(16'hFE00);
    chk(16'(flt), 16'h0001);
    finish_test();
  end
endmodule
`default_nettype wire
